//--- bench/otwsr_host.sv
// Purpose: host model issuing one register command at a time
// Assumes: answer is registered on the taking edge and read 1 ns after it
// Notes: last answer kept in got for the bench
`timescale 1ns/1ps
module otwsr_host (
  input wire logic sys_clk,
  output otwsr_pkg::otwsr_cmd_t cmd,
  input wire otwsr_pkg::otwsr_rsp_t rsp
);
  import otwsr_pkg::*;
  otwsr_rsp_t got;
  initial cmd = '0;
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge sys_clk);
    cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
    @(posedge sys_clk);
    cmd <= '0;
    #1;
    got = rsp;
  endtask
endmodule

//--- bench/otwsr_regs_bench.sv
// Purpose: self-checking bench for the warning and startup timing registers
// Assumes: 40 MHz clock, synchronous reset
// Notes: delay and ramp sweeps cover every bucket, upper bits random
`timescale 1ns/1ps
module otwsr_regs_bench;
  import otwsr_pkg::*;
  logic sys_clk, rst, clear_faults, store_all, nvm_restore, loop_slave_pin, ss_detect_pin;
  logic [10:0] temp_sensed, fault_limit;
  logic [7:0] vendor_config_word;
  logic [15:0] nvm_turn_on_delay_time, nvm_output_ramp_time;
  logic [6:0] ss_mantissa, md, mr;
  otwsr_cmd_t cmd;
  otwsr_rsp_t rsp_ff;
  otwsr_stat_t stat_ff;
  otwsr_nvm_t nvm_ff;
  logic overtemp_warning_level_ff, smbalert_ff;
  logic [21:0] eff_delay_cyc_ff, eff_rise_cyc_ff;
  logic [31:0] seed;
  int err_count = 0;
  int compares = 0;
  int hi_tab [15] = '{0, 1, 2, 3, 4, 5, 6, 9, 12, 17, 22, 32, 44, 62, 86};
  int ms_tab [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 14, 19, 27, 37, 52, 72};

  otwsr_regs otwsr_regs_inst (.sys_clk, .rst, .cmd, .temp_sensed, .fault_limit, .vendor_config_word,
    .clear_faults, .store_all, .nvm_restore, .nvm_turn_on_delay_time, .nvm_output_ramp_time, .loop_slave_pin,
    .ss_detect_pin, .ss_mantissa, .rsp_ff, .stat_ff, .overtemp_warning_level_ff, .smbalert_ff,
    .nvm_ff, .eff_delay_cyc_ff, .eff_rise_cyc_ff);
  otwsr_host otwsr_host_inst (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp_ff));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int bkt_ms(input int m);
    for (int i = 0; i < 15; i++) begin
      if (m <= hi_tab[i]) return ms_tab[i];
    end
    return 100;
  endfunction
  function automatic logic [39:0] exp_delay(input int m);
    return (m == 0) ? 40'(ZERO_DELAY_US * CYC_PER_US) : 40'(bkt_ms(m) * CYC_PER_MS);
  endfunction
  function automatic logic [39:0] exp_rise(input int m);
    return (m <= 1) ? 40'(CYC_PER_MS) : 40'(bkt_ms(m) * CYC_PER_MS);
  endfunction

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    otwsr_host_inst.send(1'b0, c, 16'h0);
    check("read", 40'(otwsr_host_inst.got), 40'({2'b10, e}));
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    otwsr_host_inst.send(1'b1, c, d);
    check("ack", 40'(otwsr_host_inst.got.valid), 40'h1);
  endtask
  task automatic clr();
    @(posedge sys_clk);
    clear_faults <= 1'b1;
    @(posedge sys_clk);
    clear_faults <= 1'b0;
    tick(2);
  endtask
  task automatic do_reset(input logic ls, input logic ss, input logic [10:0] f);
    @(posedge sys_clk);
    rst <= 1'b1;
    loop_slave_pin <= ls;
    ss_detect_pin <= ss;
    fault_limit <= f;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    tick(5);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    {clear_faults, store_all, nvm_restore, loop_slave_pin, ss_detect_pin} = '0;
    temp_sensed = 11'h019;
    fault_limit = 11'h091;
    vendor_config_word = 8'h00;
    nvm_turn_on_delay_time = 16'h0011;
    nvm_output_ramp_time = 16'h0020;
    ss_mantissa = 7'h09;
    seed = 32'hc5a4a456;
    do_reset(1'b0, 1'b0, 11'h091);
    check("stat", 40'(stat_ff), 40'h0);
    check("eff_delay", 40'(eff_delay_cyc_ff), exp_delay(0));
    check("eff_rise", 40'(eff_rise_cyc_ff), exp_rise(3));
    rd(CMD_OT_WARN, OT_WARN_RST);
    rd(CMD_TURN_ON_DELAY_TIME, TURN_ON_DELAY_TIME_RST);
    rd(CMD_OUTPUT_RAMP_TIME, OUTPUT_RAMP_TIME_RST);
    wr(CMD_OT_WARN, 16'hf882);
    rd(CMD_OT_WARN, 16'h0082);
    // Equal to fault limit is refused
    @(posedge sys_clk);
    fault_limit <= 11'h082;
    wr(CMD_OT_WARN, 16'h0078);
    wr(CMD_OT_WARN, 16'h0082);
    rd(CMD_OT_WARN, 16'h0078);
    check("stat", 40'(stat_ff), 40'h06);
    check("alert", 40'(smbalert_ff), 40'h1);
    clr();
    check("alert", 40'(smbalert_ff), 40'h0);
    @(posedge sys_clk);
    vendor_config_word <= 8'h10;
    wr(CMD_OT_WARN, 16'h008c);
    rd(CMD_OT_WARN, 16'h008c);
    check("stat", 40'(stat_ff), 40'h0);
    wr(CMD_OT_WARN, 16'h0063);
    wr(CMD_OT_WARN, 16'h008d);
    rd(CMD_OT_WARN, 16'h008c);
    @(posedge sys_clk);
    vendor_config_word <= 8'h00;
    clr();
    @(posedge sys_clk);
    temp_sensed <= 11'h08d;
    tick(3);
    check("warn", 40'(overtemp_warning_level_ff), 40'h1);
    check("stat", 40'(stat_ff), 40'h18);
    check("alert", 40'(smbalert_ff), 40'h1);
    @(posedge sys_clk);
    temp_sensed <= 11'h079;
    tick(3);
    check("warn", 40'(overtemp_warning_level_ff), 40'h1);
    @(posedge sys_clk);
    temp_sensed <= 11'h078;
    tick(3);
    check("warn", 40'(overtemp_warning_level_ff), 40'h0);
    clr();
    check("stat", 40'(stat_ff), 40'h0);
    for (int i = 0; i < 160; i++) begin
      seed = lfsr(seed);
      md = (i < 128) ? 7'(i) : seed[6:0];
      mr = (i < 128) ? 7'(127 - i) : seed[13:7];
      wr(CMD_TURN_ON_DELAY_TIME, {seed[31:23], md});
      wr(CMD_OUTPUT_RAMP_TIME, {seed[24:16], mr});
      rd(CMD_TURN_ON_DELAY_TIME, {9'h0, md});
      rd(CMD_OUTPUT_RAMP_TIME, {9'h0, mr});
      check("eff_delay", 40'(eff_delay_cyc_ff), exp_delay(md));
      check("eff_rise", 40'(eff_rise_cyc_ff), exp_rise(mr));
    end
    @(posedge sys_clk);
    store_all <= 1'b1;
    @(posedge sys_clk);
    store_all <= 1'b0;
    #1;
    check("nvm", 40'(nvm_ff), 40'({1'b1, 9'h0, md, 9'h0, mr}));
    // Restore without soft-start: both words reload, default re-derived
    @(posedge sys_clk);
    nvm_restore <= 1'b1;
    @(posedge sys_clk);
    nvm_restore <= 1'b0;
    tick(2);
    rd(CMD_OT_WARN, 16'h0069);
    rd(CMD_TURN_ON_DELAY_TIME, 16'h0011);
    rd(CMD_OUTPUT_RAMP_TIME, 16'h0020);
    do_reset(1'b0, 1'b1, 11'h06e);
    rd(CMD_OT_WARN, WARN_MIN);
    rd(CMD_OUTPUT_RAMP_TIME, 16'h0009);
    @(posedge sys_clk);
    nvm_restore <= 1'b1;
    @(posedge sys_clk);
    nvm_restore <= 1'b0;
    tick(2);
    rd(CMD_TURN_ON_DELAY_TIME, 16'h0011);
    rd(CMD_OUTPUT_RAMP_TIME, 16'h0009);
    do_reset(1'b1, 1'b0, 11'h0a0);
    rd(CMD_OT_WARN, 16'h0087);
    otwsr_host_inst.send(1'b0, CMD_TURN_ON_DELAY_TIME, 16'h0);
    check("nack", 40'(otwsr_host_inst.got), 40'h30000);
    otwsr_host_inst.send(1'b1, CMD_TURN_ON_DELAY_TIME, 16'h0040);
    check("nack", 40'(otwsr_host_inst.got), 40'h30000);
    otwsr_host_inst.send(1'b1, CMD_OUTPUT_RAMP_TIME, 16'h0005);
    tick(3);
    check("stat", 40'(stat_ff), 40'h05);
    check("alert", 40'(smbalert_ff), 40'h1);
    check("eff_delay", 40'(eff_delay_cyc_ff), exp_delay(0));
    check("eff_rise", 40'(eff_rise_cyc_ff), 40'(SLAVE_RISE_MS * CYC_PER_MS));
    print_verdict();
  end
endmodule

//--- hw/otwsr_pkg.sv
// Purpose: constants and types for the overtemperature warning and startup timing commands
// Assumes: 40 MHz sys_clk, command-level access from the bus protocol engine
// Notes: delay and ramp tables share one bucket map
package otwsr_pkg;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
  localparam logic [7:0] CMD_OUTPUT_RAMP_TIME = 8'h61;
  localparam logic [15:0] OT_WARN_RST = 16'h0078;
  localparam logic [15:0] TURN_ON_DELAY_TIME_RST = 16'h0000;
  localparam logic [15:0] OUTPUT_RAMP_TIME_RST = 16'h0003;
  localparam logic [10:0] WARN_MIN = 11'h064;
  localparam logic [10:0] WARN_MAX = 11'h08c;
  localparam logic [10:0] WARN_OFFS = 11'h019;
  localparam logic [11:0] WARN_HYST = 12'h014;
  localparam int MANT_W = 11;
  localparam int TIME_W = 7;
  localparam int DLO_BIT = 4;
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;
  localparam int ZERO_DELAY_US = 50;
  localparam int SLAVE_RISE_MS = 100;
  localparam int MIN_RISE_MS = 1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Upper bound of each bucket, last bucket open ended
  localparam logic [6:0] BKT_HI [16] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h09,
                                        7'h0c, 7'h11, 7'h16, 7'h20, 7'h2c, 7'h3e, 7'h56, 7'h7f};
  // Effective time of each bucket in ms, bucket 0 is the sub-ms case
  localparam int BKT_MS [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 14, 19, 27, 37, 52, 72, 100};

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } otwsr_cmd_t;

  typedef struct packed {
    logic valid;
    logic nack;
    logic [15:0] data;
  } otwsr_rsp_t;

  typedef struct packed {
    logic temp_summary;
    logic ot_warn_status;
    logic comm_error_summary;
    logic invalid_data;
    logic invalid_command_fault;
  } otwsr_stat_t;

  typedef struct packed {
    logic valid;
    logic [15:0] turn_on_delay_time;
    logic [15:0] output_ramp_time;
  } otwsr_nvm_t;

  function automatic logic [3:0] otwsr_bucket(input logic [6:0] m);
    logic [3:0] b;
    b = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (m > BKT_HI[i]) begin
        b = 4'(i + 1);
      end
    end
    return b;
  endfunction
endpackage

//--- hw/otwsr_regs.sv
// Purpose: warning threshold, turn-on delay and ramp time command registers
// Assumes: temperature, fault limit and decoder inputs come from sys_clk logic
// Notes: straps are synchronised and caught once after reset
//
// Operation
// - Over-limit temperature sets status bits and alert
// - Warning latched until 20 below threshold
// - Threshold at or above fault limit refused
// - Override bit skips fault limit comparison
// - Default threshold is max(fault-25, 100)
// - Threshold exponent zero, mantissa default 120
// - Threshold mantissa spans 100 to 140
// - Delay sets start-to-rise interval in ms
// - Store-all saves delay and ramp words
// - Loop slave delay and ramp access NACKed, fault, alert
// - Delay exponent zero, seven writable bits
// - Delay mantissa quantized into 16 buckets
// - Zero delay mantissa gives 50 us
// - Ramp sets reference-rise-to-regulation time
// - Zero ramp gives fastest 1 ms
// - Soft-start pin value overrides restored ramp
// - Ramp seven writable bits, default 3 ms
// - Loop slave ramp fixed at 100 ms
`timescale 1ns/1ps
module otwsr_regs
  import otwsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire otwsr_pkg::otwsr_cmd_t cmd,
  input wire logic [10:0] temp_sensed,
  input wire logic [10:0] fault_limit,
  input wire logic [7:0] vendor_config_word,
  input wire logic clear_faults,
  input wire logic store_all,
  input wire logic nvm_restore,
  input wire logic [15:0] nvm_turn_on_delay_time,
  input wire logic [15:0] nvm_output_ramp_time,
  input wire logic loop_slave_pin,
  input wire logic ss_detect_pin,
  input wire logic [6:0] ss_mantissa,
  output otwsr_pkg::otwsr_rsp_t rsp_ff,
  output otwsr_pkg::otwsr_stat_t stat_ff,
  output logic overtemp_warning_level_ff,
  output logic smbalert_ff,
  output otwsr_pkg::otwsr_nvm_t nvm_ff,
  output logic [21:0] eff_delay_cyc_ff,
  output logic [21:0] eff_rise_cyc_ff
);
  import otwsr_pkg::*;

  typedef enum logic [1:0] {ST_INIT = 2'b01, ST_RUN = 2'b10} otwsr_state_t;

  otwsr_state_t state_ff;
  logic [1:0] init_cnt_ff;
  logic [1:0] slave_sync_ff;
  logic [1:0] ss_sync_ff;
  logic loop_slave_ff;
  logic ss_active_ff;
  logic [10:0] warn_ff;
  logic [6:0] delay_ff;
  logic [6:0] rise_ff;
  logic [10:0] warn_dflt;
  logic is_warn;
  logic is_time;
  logic slave_block;
  logic warn_bad;
  logic warn_wr_ok;
  logic time_wr_ok;
  logic init_done;
  otwsr_stat_t nxt_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slave_sync_ff <= 2'h0;
      ss_sync_ff <= 2'h0;
    end else begin
      slave_sync_ff <= {slave_sync_ff[0], loop_slave_pin};
      ss_sync_ff <= {ss_sync_ff[0], ss_detect_pin};
    end
  end

  assign init_done = (state_ff == ST_INIT) && (init_cnt_ff == STRAP_WAIT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_INIT;
      init_cnt_ff <= 2'h0;
      loop_slave_ff <= 1'b0;
      ss_active_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_INIT: begin
          init_cnt_ff <= init_cnt_ff + 2'h1;
          if (init_done) begin
            state_ff <= ST_RUN;
            loop_slave_ff <= slave_sync_ff[1];
            ss_active_ff <= ss_sync_ff[1];
          end
        end
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign is_warn = cmd.valid && (state_ff == ST_RUN) && (cmd.code == CMD_OT_WARN);
  assign is_time = cmd.valid && (state_ff == ST_RUN) &&
                   ((cmd.code == CMD_TURN_ON_DELAY_TIME) || (cmd.code == CMD_OUTPUT_RAMP_TIME));
  assign slave_block = is_time && loop_slave_ff;
  assign warn_bad = (cmd.data[10:0] < WARN_MIN) || (cmd.data[10:0] > WARN_MAX) ||
                    (!vendor_config_word[DLO_BIT] && (cmd.data[10:0] >= fault_limit));
  assign warn_wr_ok = is_warn && cmd.write && !warn_bad;
  assign time_wr_ok = is_time && cmd.write && !loop_slave_ff;
  assign warn_dflt = (fault_limit < WARN_MIN + WARN_OFFS) ? WARN_MIN : fault_limit - WARN_OFFS;

  ////////////////////////////////////////////////////////////////////////////
  // Warning threshold
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_ff <= OT_WARN_RST[10:0];
    end else if (init_done || nvm_restore) begin
      warn_ff <= warn_dflt;
    end else if (warn_wr_ok) begin
      warn_ff <= cmd.data[10:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overtemp_warning_level_ff <= 1'b0;
    end else if (temp_sensed > warn_ff) begin
      overtemp_warning_level_ff <= 1'b1;
    end else if ({1'b0, temp_sensed} + WARN_HYST <= {1'b0, warn_ff}) begin
      overtemp_warning_level_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay and ramp words
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      delay_ff <= TURN_ON_DELAY_TIME_RST[6:0];
    end else if (nvm_restore) begin
      delay_ff <= nvm_turn_on_delay_time[6:0];
    end else if (time_wr_ok && cmd.code == CMD_TURN_ON_DELAY_TIME) begin
      delay_ff <= cmd.data[6:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rise_ff <= OUTPUT_RAMP_TIME_RST[6:0];
    end else if (init_done && ss_sync_ff[1]) begin
      rise_ff <= ss_mantissa;
    end else if (nvm_restore && !ss_active_ff) begin
      rise_ff <= nvm_output_ramp_time[6:0];
    end else if (time_wr_ok && cmd.code == CMD_OUTPUT_RAMP_TIME) begin
      rise_ff <= cmd.data[6:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eff_delay_cyc_ff <= 22'(ZERO_DELAY_US * CYC_PER_US);
    end else if (delay_ff == 7'h00) begin
      eff_delay_cyc_ff <= 22'(ZERO_DELAY_US * CYC_PER_US);
    end else begin
      eff_delay_cyc_ff <= 22'(BKT_MS[otwsr_bucket(delay_ff)] * CYC_PER_MS);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eff_rise_cyc_ff <= 22'(BKT_MS[otwsr_bucket(OUTPUT_RAMP_TIME_RST[6:0])] * CYC_PER_MS);
    end else if (loop_slave_ff) begin
      eff_rise_cyc_ff <= 22'(SLAVE_RISE_MS * CYC_PER_MS);
    end else if (rise_ff <= 7'h01) begin
      eff_rise_cyc_ff <= 22'(MIN_RISE_MS * CYC_PER_MS);
    end else begin
      eff_rise_cyc_ff <= 22'(BKT_MS[otwsr_bucket(rise_ff)] * CYC_PER_MS);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nvm_ff <= '0;
    end else begin
      nvm_ff.valid <= store_all;
      nvm_ff.turn_on_delay_time <= {9'h000, delay_ff};
      nvm_ff.output_ramp_time <= {9'h000, rise_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= is_warn || is_time;
      rsp_ff.nack <= slave_block;
      if (is_warn) begin
        rsp_ff.data <= {5'h00, warn_ff};
      end else if (is_time && !loop_slave_ff) begin
        rsp_ff.data <= {9'h000, (cmd.code == CMD_TURN_ON_DELAY_TIME) ? delay_ff : rise_ff};
      end else begin
        rsp_ff.data <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and alert, set wins over clear
  always_comb begin
    nxt_stat = clear_faults ? '0 : stat_ff;
    if (temp_sensed > warn_ff) begin
      nxt_stat.temp_summary = 1'b1;
      nxt_stat.ot_warn_status = 1'b1;
    end
    if (is_warn && cmd.write && warn_bad) begin
      nxt_stat.comm_error_summary = 1'b1;
      nxt_stat.invalid_data = 1'b1;
    end
    if (slave_block) begin
      nxt_stat.comm_error_summary = 1'b1;
      nxt_stat.invalid_command_fault = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_ff <= '0;
      smbalert_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      smbalert_ff <= |nxt_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_warn_set;
    @(posedge sys_clk) disable iff (rst) (temp_sensed > warn_ff) |=> stat_ff.ot_warn_status && smbalert_ff;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning not flagged");

  property p_hyst_hold;
    @(posedge sys_clk) disable iff (rst)
      overtemp_warning_level_ff && ({1'b0, temp_sensed} + WARN_HYST > {1'b0, warn_ff}) |=> overtemp_warning_level_ff;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("warning dropped early");

  property p_refuse;
    @(posedge sys_clk) disable iff (rst)
      is_warn && cmd.write && warn_bad && !nvm_restore |=> $stable(warn_ff) && stat_ff.invalid_data;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad threshold accepted");

  property p_override;
    @(posedge sys_clk) disable iff (rst)
      warn_wr_ok && !nvm_restore && vendor_config_word[DLO_BIT] |=> warn_ff == $past(cmd.data[10:0]);
  endproperty
  a_override: assert property (p_override) else $error("override write lost");

  property p_range;
    @(posedge sys_clk) disable iff (rst) state_ff == ST_RUN |-> warn_ff >= WARN_MIN && warn_ff <= WARN_MAX + 11'h0;
  endproperty
  a_range: assert property (p_range) else $error("threshold out of range");

  property p_slave_nack;
    @(posedge sys_clk) disable iff (rst) slave_block |=> rsp_ff.nack && stat_ff.invalid_command_fault && smbalert_ff;
  endproperty
  a_slave_nack: assert property (p_slave_nack) else $error("slave access not refused");

  property p_zero_delay;
    @(posedge sys_clk) disable iff (rst) delay_ff == 7'h00 |=> eff_delay_cyc_ff == 22'h0007d0;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay wrong");

  property p_zero_rise;
    @(posedge sys_clk) disable iff (rst) rise_ff == 7'h00 && !loop_slave_ff |=> eff_rise_cyc_ff == 22'h009c40;
  endproperty
  a_zero_rise: assert property (p_zero_rise) else $error("zero ramp wrong");

  property p_slave_rise;
    @(posedge sys_clk) disable iff (rst) loop_slave_ff |=> eff_rise_cyc_ff == 22'h3d0900;
  endproperty
  a_slave_rise: assert property (p_slave_rise) else $error("slave ramp not fixed");

  property p_store;
    @(posedge sys_clk) disable iff (rst) store_all |=> nvm_ff.valid && nvm_ff.output_ramp_time[15:7] == 9'h000;
  endproperty
  a_store: assert property (p_store) else $error("store snapshot missing");

  c_warn: cover property (@(posedge sys_clk) disable iff (rst) overtemp_warning_level_ff ##[1:50] !overtemp_warning_level_ff);
  c_refuse: cover property (@(posedge sys_clk) disable iff (rst) is_warn && cmd.write && warn_bad);
  c_slave: cover property (@(posedge sys_clk) disable iff (rst) slave_block);
  c_delay_wr: cover property (@(posedge sys_clk) disable iff (rst) time_wr_ok ##2 eff_delay_cyc_ff != $past(eff_delay_cyc_ff));
endmodule
